// ### verilog/dsad_params.svh
`ifndef DSAD_PARAMS_SVH
`define DSAD_PARAMS_SVH

// ==================== data map
`define DSAD_RAM_LO 24'h000000
`define DSAD_RAM_HI 24'h000fff
`define DSAD_DF_LO 24'h001000
`define DSAD_DF_HI 24'h001fff
`define DSAD_PER_LO 24'h00f000
`define DSAD_PER_HI 24'h00ffff
`define DSAD_DBG_LO 24'hff0000
`define DSAD_DBG_HI 24'hffffff

// ==================== flash configuration words
`define DSAD_CFG_FIRST 16'hfff7
`define DSAD_CFG_LAST_IDX 4'h8

// ==================== flash geometry, as address shifts
`define DSAD_PF_SECT_SH 12
`define DSAD_PF_PAGE_SH 9
`define DSAD_DF_SECT_SH 8
`define DSAD_DF_PAGE_SH 8
`define DSAD_BF_SECT_SH 10
`define DSAD_BF_PAGE_SH 8

// ==================== vectors
`define DSAD_VBA_RESET_A 16'h0200
`define DSAD_VBA_RESET_B 16'h0000
`define DSAD_VEC_HI_BITS 3

`endif

// ### verilog/dsad_pkg.sv
`default_nettype none
package dsad_pkg;
	typedef enum logic [2:0] {
		DSAD_TGT_NONE = 3'b000,
		DSAD_TGT_RAM = 3'b001,
		DSAD_TGT_DFLASH = 3'b010,
		DSAD_TGT_PERIPH = 3'b011,
		DSAD_TGT_DEBUG = 3'b100,
		DSAD_TGT_EXT = 3'b101
	} dsad_tgt_t;

	typedef struct packed {
		logic valid;
		logic wr;
		logic lng;
		logic [23:0] addr;
		logic [31:0] wdata;
	} dsad_req_t;

	typedef struct packed {
		logic valid;
		logic wr;
		logic lng;
		dsad_tgt_t tgt;
		logic [23:0] addr;
		logic [31:0] wdata;
	} dsad_sel_t;

	typedef struct packed {
		logic [3:0] sector;
		logic [6:0] page;
	} dsad_geom_t;

	typedef enum logic [1:0] {
		DSAD_INIT_ISSUE = 2'b00,
		DSAD_INIT_WAIT = 2'b01,
		DSAD_INIT_DONE = 2'b10
	} dsad_init_t;
endpackage : dsad_pkg
`default_nettype wire

// ### verilog/dsad_ram.sv
`default_nettype none
module dsad_ram (
	input wire logic sys_clk,
	input wire logic en,
	input wire logic wr,
	input wire logic lng,
	input wire logic [10:0] idx,
	input wire logic half,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata_ff
);
	// ==================== storage
	logic [31:0] mem [0:2047];

	// one entry holds both words of a long, so no second cycle is needed
	always_ff @(posedge sys_clk) begin
		if (en && wr) begin
			if (lng) begin
				mem[idx] <= wdata;
			end else if (half) begin
				mem[idx][31:16] <= wdata[15:0];
			end else begin
				mem[idx][15:0] <= wdata[15:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (en && !wr) begin
			if (lng) begin
				rdata_ff <= mem[idx];
			end else begin
				rdata_ff <= {16'h0000, half ? mem[idx][31:16] : mem[idx][15:0]};
			end
		end
	end
endmodule : dsad_ram
`default_nettype wire

// ### verilog/dsad_decoder.sv
`include "dsad_params.svh"
`default_nettype none
module dsad_decoder (
	input wire logic sys_clk,
	input wire logic rst,
	input wire dsad_pkg::dsad_req_t dreq,
	input wire logic ext_data_mode_bit,
	input wire logic boot_mode1,
	input wire logic ext_mem_mode,
	input wire logic [15:0] pf_rdata,
	input wire logic pf_rvalid,
	input wire logic pbus_valid,
	input wire logic pbus_boot,
	input wire logic [15:0] pbus_addr,
	input wire logic vec_req,
	input wire logic [15:0] vector_base,
	input wire logic [6:0] vec_num,
	input wire logic [15:0] vec_lo,
	input wire logic [15:0] vec_hi,
	output dsad_pkg::dsad_sel_t dsel_ff,
	output logic [31:0] ram_rdata_ff,
	output logic periph_size_err_ff,
	output dsad_pkg::dsad_geom_t df_geom_ff,
	output logic pf_rd_ff,
	output logic [15:0] pf_addr_ff,
	output logic [8:0][15:0] flash_cfg_ff,
	output logic init_done_ff,
	output logic pf_reg_sel_ff,
	output dsad_pkg::dsad_geom_t pf_geom_ff,
	output logic vec_valid_ff,
	output logic vec_reset_ff,
	output logic [18:0] vec_addr_ff,
	output logic [18:0] vec_target_ff
);
	// ==================== functions
	function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	function automatic dsad_pkg::dsad_geom_t geom(input logic [15:0] off, input int ssh, input int psh);
		logic [15:0] s;
		logic [15:0] p;
		s = off >> ssh;
		p = off >> psh;
		geom.sector = s[3:0];
		geom.page = p[6:0];
	endfunction : geom

	// addresses are word addresses, no byte lane ever enters the compare
	function automatic dsad_pkg::dsad_tgt_t decode(input logic [23:0] a, input logic ex);
		if (in_rng(a, `DSAD_DBG_LO, `DSAD_DBG_HI)) begin
			decode = dsad_pkg::DSAD_TGT_DEBUG;
		end else if (in_rng(a, `DSAD_PER_LO, `DSAD_PER_HI)) begin
			decode = dsad_pkg::DSAD_TGT_PERIPH;
		end else if (!ex && in_rng(a, `DSAD_RAM_LO, `DSAD_RAM_HI)) begin
			decode = dsad_pkg::DSAD_TGT_RAM;
		end else if (!ex && in_rng(a, `DSAD_DF_LO, `DSAD_DF_HI)) begin
			decode = dsad_pkg::DSAD_TGT_DFLASH;
		end else begin
			decode = dsad_pkg::DSAD_TGT_EXT;
		end
	endfunction : decode

	// ==================== data bus decode
	dsad_pkg::dsad_tgt_t nxt_tgt;
	logic [15:0] df_off;

	assign nxt_tgt = decode(dreq.addr, ext_data_mode_bit);
	assign df_off = 16'(dreq.addr[15:0] - `DSAD_DF_LO);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dsel_ff <= '0;
		end else begin
			dsel_ff.valid <= dreq.valid;
			dsel_ff.wr <= dreq.wr;
			dsel_ff.lng <= dreq.lng;
			dsel_ff.tgt <= dreq.valid ? nxt_tgt : dsad_pkg::DSAD_TGT_NONE;
			dsel_ff.addr <= dreq.addr;
			dsel_ff.wdata <= dreq.wdata;
		end
	end

	// peripherals only take words; a long there is flagged, not split
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			periph_size_err_ff <= 1'b0;
		end else begin
			periph_size_err_ff <= dreq.valid && dreq.lng && (nxt_tgt == dsad_pkg::DSAD_TGT_PERIPH);
		end
	end

	// data flash keeps its own bank; geometry from the window offset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			df_geom_ff <= '0;
		end else if (dreq.valid && nxt_tgt == dsad_pkg::DSAD_TGT_DFLASH) begin
			df_geom_ff <= geom(df_off, `DSAD_DF_SECT_SH, `DSAD_DF_PAGE_SH);
		end
	end

	// ==================== data ram
	logic ram_en;
	assign ram_en = dreq.valid && (nxt_tgt == dsad_pkg::DSAD_TGT_RAM);

	dsad_ram u_ram (
		.sys_clk(sys_clk),
		.en(ram_en),
		.wr(dreq.wr),
		.lng(dreq.lng),
		.idx(dreq.addr[11:1]),
		.half(dreq.addr[0]),
		.wdata(dreq.wdata),
		.rdata_ff(ram_rdata_ff)
	);

	// ==================== flash configuration load
	dsad_pkg::dsad_init_t init_ff;
	logic [3:0] cfg_idx_ff;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			init_ff <= dsad_pkg::DSAD_INIT_ISSUE;
			cfg_idx_ff <= 4'h0;
			pf_rd_ff <= 1'b0;
			pf_addr_ff <= 16'h0000;
		end else begin
			pf_rd_ff <= 1'b0;
			unique case (init_ff)
				dsad_pkg::DSAD_INIT_ISSUE: begin
					pf_rd_ff <= 1'b1;
					pf_addr_ff <= `DSAD_CFG_FIRST + {12'h000, cfg_idx_ff};
					init_ff <= dsad_pkg::DSAD_INIT_WAIT;
				end
				dsad_pkg::DSAD_INIT_WAIT: begin
					if (pf_rvalid) begin
						if (cfg_idx_ff == `DSAD_CFG_LAST_IDX) begin
							init_ff <= dsad_pkg::DSAD_INIT_DONE;
						end else begin
							cfg_idx_ff <= cfg_idx_ff + 4'h1;
							init_ff <= dsad_pkg::DSAD_INIT_ISSUE;
						end
					end
				end
				dsad_pkg::DSAD_INIT_DONE: begin
					init_ff <= dsad_pkg::DSAD_INIT_DONE;
				end
				default: begin
					init_ff <= dsad_pkg::DSAD_INIT_ISSUE;
				end
			endcase
		end
	end

	// reset clears the words in the array, so they are reloaded every time
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flash_cfg_ff <= '0;
		end else if (init_ff == dsad_pkg::DSAD_INIT_WAIT && pf_rvalid) begin
			flash_cfg_ff[cfg_idx_ff] <= pf_rdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			init_done_ff <= 1'b0;
		end else begin
			init_done_ff <= (init_ff == dsad_pkg::DSAD_INIT_DONE);
		end
	end

	// ==================== program bus flash geometry
	// program and boot arrays answer to the same banked register set
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pf_reg_sel_ff <= 1'b0;
			pf_geom_ff <= '0;
		end else begin
			pf_reg_sel_ff <= pbus_valid;
			if (pbus_valid) begin
				if (pbus_boot) begin
					pf_geom_ff <= geom(pbus_addr, `DSAD_BF_SECT_SH, `DSAD_BF_PAGE_SH);
				end else begin
					pf_geom_ff <= geom(pbus_addr, `DSAD_PF_SECT_SH, `DSAD_PF_PAGE_SH);
				end
			end
		end
	end

	// ==================== vector fetch
	logic vec_is_reset;
	logic [18:0] nxt_vec_addr;

	assign vec_is_reset = (vec_num == 7'h00) && ((vector_base == `DSAD_VBA_RESET_A) ||
		((vector_base == `DSAD_VBA_RESET_B) && boot_mode1 && !ext_mem_mode));
	assign nxt_vec_addr = {3'b000, vector_base} + {11'h000, vec_num, 1'b0};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			vec_valid_ff <= 1'b0;
			vec_reset_ff <= 1'b0;
			vec_addr_ff <= 19'h00000;
			vec_target_ff <= 19'h00000;
		end else begin
			vec_valid_ff <= vec_req && !vec_is_reset;
			vec_reset_ff <= vec_req && vec_is_reset;
			if (vec_req) begin
				vec_addr_ff <= nxt_vec_addr;
				// only three bits of the upper word fit the reach
				vec_target_ff <= {vec_hi[`DSAD_VEC_HI_BITS-1:0], vec_lo};
			end
		end
	end

	// ==================== assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_cfg_issue;
		init_ff == dsad_pkg::DSAD_INIT_ISSUE ##1 pf_rd_ff;
	endsequence

	sequence s_cfg_take;
		init_ff == dsad_pkg::DSAD_INIT_WAIT && pf_rvalid;
	endsequence

	a_periph_window: assert property (dreq.valid && in_rng(dreq.addr, `DSAD_PER_LO, `DSAD_PER_HI)
		|=> dsel_ff.tgt == dsad_pkg::DSAD_TGT_PERIPH) else $error("peripheral window missed");

	a_debug_window: assert property (dreq.valid && dreq.addr[23:16] == 8'hff
		|=> dsel_ff.tgt == dsad_pkg::DSAD_TGT_DEBUG) else $error("debug window missed");

	a_low_onchip: assert property (dreq.valid && !ext_data_mode_bit && dreq.addr < 24'h002000
		|=> dsel_ff.tgt == (dsel_ff.addr[12] ? dsad_pkg::DSAD_TGT_DFLASH : dsad_pkg::DSAD_TGT_RAM))
		else $error("low range not on chip");

	a_low_external: assert property (dreq.valid && ext_data_mode_bit && dreq.addr < 24'h002000
		|=> dsel_ff.tgt == dsad_pkg::DSAD_TGT_EXT) else $error("low range not external");

	a_ext_high: assert property (dreq.valid && dreq.addr >= 24'h010000 && dreq.addr <= 24'hfeffff
		|=> dsel_ff.tgt == dsad_pkg::DSAD_TGT_EXT) else $error("upper gap not external");

	a_sel_idle: assert property (!dreq.valid
		|=> !dsel_ff.valid && dsel_ff.tgt == dsad_pkg::DSAD_TGT_NONE) else $error("idle cycle selected a target");

	a_word_address: assert property (dreq.valid |=> dsel_ff.valid && dsel_ff.addr == $past(dreq.addr))
		else $error("address altered");

	a_sel_copy: assert property (dreq.valid |=> dsel_ff.wr == $past(dreq.wr)
		&& dsel_ff.lng == $past(dreq.lng) && dsel_ff.wdata == $past(dreq.wdata))
		else $error("request fields altered");

	a_long_periph: assert property (dreq.valid && dreq.lng && dreq.addr[23:12] == 12'h00f
		|=> periph_size_err_ff) else $error("long peripheral access not flagged");

	a_periph_word: assert property (dreq.valid && !dreq.lng
		|=> !periph_size_err_ff) else $error("word access flagged");

	a_ram_word_read: assert property (dreq.valid && !dreq.wr && !dreq.lng && !ext_data_mode_bit
		&& dreq.addr <= `DSAD_RAM_HI |=> ram_rdata_ff[31:16] == 16'h0000)
		else $error("word read upper half not clear");

	a_cfg_addr: assert property (s_cfg_issue |-> pf_addr_ff == `DSAD_CFG_FIRST + {12'h000, cfg_idx_ff})
		else $error("config fetch address wrong");

	a_cfg_pulse: assert property (pf_rd_ff |=> !pf_rd_ff) else $error("config read held");

	a_cfg_store: assert property (s_cfg_take |=> flash_cfg_ff[$past(cfg_idx_ff)] == $past(pf_rdata))
		else $error("config word not stored");

	a_init_end: assert property ((s_cfg_take and (cfg_idx_ff == `DSAD_CFG_LAST_IDX))
		|=> ##1 init_done_ff [*3]) else $error("init did not finish");

	a_shared_regs: assert property (pbus_valid |=> pf_reg_sel_ff)
		else $error("program bus register set not selected");

	a_pf_geom: assert property (pbus_valid && !pbus_boot
		|=> pf_geom_ff.sector == $past(pbus_addr[15:12]) && pf_geom_ff.page == $past(pbus_addr[15:9]))
		else $error("program flash geometry wrong");

	a_bf_geom: assert property (pbus_valid && pbus_boot
		|=> pf_geom_ff.sector == $past(pbus_addr[13:10]) && pf_geom_ff.page == $past(pbus_addr[14:8]))
		else $error("boot flash geometry wrong");

	a_vec_reset: assert property (vec_req && vec_num == 7'h00 && vector_base == `DSAD_VBA_RESET_A
		|=> vec_reset_ff && !vec_valid_ff) else $error("reset entry taken as vector");

	a_vec_mode1: assert property (vec_req && vec_num == 7'h00 && vector_base == `DSAD_VBA_RESET_B
		&& boot_mode1 && !ext_mem_mode |=> vec_reset_ff && !vec_valid_ff)
		else $error("mode 1 reset entry taken as vector");

	a_vec_ext_mem: assert property (vec_req && vec_num == 7'h00 && vector_base == `DSAD_VBA_RESET_B
		&& ext_mem_mode |=> vec_valid_ff && !vec_reset_ff) else $error("external memory entry not served");

	a_vec_normal: assert property (vec_req && vec_num != 7'h00
		|=> vec_valid_ff && !vec_reset_ff) else $error("vector entry not served");

	a_vec_reach: assert property (vec_req |=> vec_target_ff == {$past(vec_hi[2:0]), $past(vec_lo)})
		else $error("vector target wrong");

	a_vec_addr: assert property (vec_req
		|=> vec_addr_ff == {3'b000, $past(vector_base)} + {11'h000, $past(vec_num), 1'b0})
		else $error("vector entry address wrong");

	a_df_geom: assert property (dreq.valid && !ext_data_mode_bit && dreq.addr[23:12] == 12'h001
		|=> df_geom_ff.sector == $past(dreq.addr[11:8]) && df_geom_ff.page == {3'b000, $past(dreq.addr[11:8])})
		else $error("data flash geometry wrong");
endmodule : dsad_decoder
`default_nettype wire

// ### verilog/dsad_note_unused.sv
`default_nettype none
`default_nettype wire

// ### tb/dsad_flash_model.sv
`default_nettype none
// ==========
// program flash seen from the config loader: odd addresses answer slowly
module dsad_flash_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic rd,
	input wire logic [15:0] addr,
	output logic rvalid_ff,
	output logic [15:0] rdata_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_ff;
	logic [15:0] addr_ff;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_ff <= 3'h0;
			addr_ff <= 16'h0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 16'h0;
		end else begin
			rvalid_ff <= 1'b0;
			// data lines toggle when not valid, so a stale read cannot pass
			rdata_ff <= ~rdata_ff;
			if (rd) begin
				addr_ff <= addr;
				cnt_ff <= addr[0] ? 3'h4 : 3'h1;
			end else if (cnt_ff == 3'h1) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= addr_ff ^ 16'ha5c3;
				cnt_ff <= 3'h0;
			end else if (cnt_ff != 3'h0) begin
				cnt_ff <= cnt_ff - 3'h1;
			end
		end
	end
endmodule : dsad_flash_model
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst, ext_data_mode_bit, boot_mode1, ext_mem_mode, pbus_valid, pbus_boot, vec_req;
	dsad_pkg::dsad_req_t dreq;
	logic [15:0] pbus_addr, vector_base, vec_lo, vec_hi, pf_addr_ff, pf_rdata;
	logic [6:0] vec_num;
	dsad_pkg::dsad_sel_t dsel_ff;
	dsad_pkg::dsad_geom_t df_geom_ff, pf_geom_ff;
	logic [31:0] ram_rdata_ff;
	logic periph_size_err_ff, pf_rd_ff, init_done_ff, pf_reg_sel_ff, vec_valid_ff, vec_reset_ff, pf_rvalid;
	logic [8:0][15:0] flash_cfg_ff;
	logic [18:0] vec_addr_ff, vec_target_ff;
	int n_fail = 0;
	int tests_run = 0;

	dsad_decoder dsad_decoder_i (.sys_clk, .rst, .dreq, .ext_data_mode_bit, .boot_mode1, .ext_mem_mode,
		.pf_rdata, .pf_rvalid, .pbus_valid, .pbus_boot, .pbus_addr, .vec_req, .vector_base, .vec_num,
		.vec_lo, .vec_hi, .dsel_ff, .ram_rdata_ff, .periph_size_err_ff, .df_geom_ff, .pf_rd_ff, .pf_addr_ff,
		.flash_cfg_ff, .init_done_ff, .pf_reg_sel_ff, .pf_geom_ff, .vec_valid_ff, .vec_reset_ff,
		.vec_addr_ff, .vec_target_ff);
	dsad_flash_model dsad_flash_model_i (.sys_clk, .rst, .rd(pf_rd_ff), .addr(pf_addr_ff),
		.rvalid_ff(pf_rvalid), .rdata_ff(pf_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========
	// helpers
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one request, answer is settled after the next edge
	task automatic acc(logic wr, logic lng, logic [23:0] a, logic [31:0] d, logic ext);
		@(posedge sys_clk);
		dreq <= '{valid: 1'b1, wr: wr, lng: lng, addr: a, wdata: d};
		ext_data_mode_bit <= ext;
		@(posedge sys_clk);
		dreq.valid <= 1'b0;
		#1;
	endtask : acc

	task automatic dec(logic [23:0] a, logic ext, logic [2:0] tgt);
		acc(1'b0, 1'b0, a, 32'h0, ext);
		chk("sel_tgt", 32'(tgt), 32'(dsel_ff.tgt));
		chk("sel_addr", 32'(a), 32'(dsel_ff.addr));
	endtask : dec

	task automatic pb(logic boot, logic [15:0] a, logic [10:0] g);
		@(posedge sys_clk);
		pbus_valid <= 1'b1;
		pbus_boot <= boot;
		pbus_addr <= a;
		@(posedge sys_clk);
		pbus_valid <= 1'b0;
		#1;
		chk("pf_reg_sel", 32'h1, 32'(pf_reg_sel_ff));
		chk("pf_geom", 32'(g), 32'(pf_geom_ff));
	endtask : pb

	task automatic vec(logic [15:0] base, logic [6:0] n, logic bm, logic em, logic [15:0] hi, logic rs);
		@(posedge sys_clk);
		vec_req <= 1'b1;
		vector_base <= base;
		vec_num <= n;
		boot_mode1 <= bm;
		ext_mem_mode <= em;
		vec_lo <= 16'h1234;
		vec_hi <= hi;
		@(posedge sys_clk);
		vec_req <= 1'b0;
		#1;
		chk("vec_reset", 32'(rs), 32'(vec_reset_ff));
		chk("vec_valid", 32'(!rs), 32'(vec_valid_ff));
		chk("vec_addr", 32'(19'(base) + 19'({n, 1'b0})), 32'(vec_addr_ff));
		chk("vec_target", 32'({hi[2:0], 16'h1234}), 32'(vec_target_ff));
	endtask : vec

	// ==========
	// scenarios
	task automatic t_init();
		int i;
		i = 0;
		while (init_done_ff !== 1'b1 && i < 300) begin
			@(posedge sys_clk);
			i++;
		end
		if (i == 300) begin
			n_fail++;
			end_sim();
		end
		#1;
		for (int k = 0; k < 9; k++) begin
			chk("cfg_word", 32'(16'(16'hfff7 + k) ^ 16'ha5c3), 32'(flash_cfg_ff[k]));
		end
		chk("pf_addr_last", 32'h0000ffff, 32'(pf_addr_ff));
		chk("pf_rd_idle", 32'h0, 32'(pf_rd_ff));
		$display("test init done");
	endtask : t_init

	task automatic t_decode();
		dec(24'h000000, 1'b0, dsad_pkg::DSAD_TGT_RAM);
		dec(24'h000fff, 1'b0, dsad_pkg::DSAD_TGT_RAM);
		dec(24'h000fff, 1'b1, dsad_pkg::DSAD_TGT_EXT);
		dec(24'h001000, 1'b0, dsad_pkg::DSAD_TGT_DFLASH);
		dec(24'h001fff, 1'b1, dsad_pkg::DSAD_TGT_EXT);
		dec(24'h002000, 1'b0, dsad_pkg::DSAD_TGT_EXT);
		dec(24'h00f000, 1'b1, dsad_pkg::DSAD_TGT_PERIPH);
		dec(24'h00ffff, 1'b0, dsad_pkg::DSAD_TGT_PERIPH);
		dec(24'h010000, 1'b0, dsad_pkg::DSAD_TGT_EXT);
		dec(24'hfeffff, 1'b1, dsad_pkg::DSAD_TGT_EXT);
		dec(24'hff0000, 1'b1, dsad_pkg::DSAD_TGT_DEBUG);
		dec(24'hffffff, 1'b0, dsad_pkg::DSAD_TGT_DEBUG);
		$display("test decode done");
	endtask : t_decode

	task automatic t_ram();
		acc(1'b1, 1'b1, 24'h000004, 32'h89abcdef, 1'b0);
		chk("sel_wdata", 32'h89abcdef, dsel_ff.wdata);
		chk("sel_wr", 32'h1, 32'(dsel_ff.wr));
		chk("sel_lng", 32'h1, 32'(dsel_ff.lng));
		acc(1'b0, 1'b1, 24'h000004, 32'h0, 1'b0);
		chk("ram_long", 32'h89abcdef, ram_rdata_ff);
		acc(1'b0, 1'b0, 24'h000005, 32'h0, 1'b0);
		chk("ram_high_word", 32'h000089ab, ram_rdata_ff);
		$display("test ram done");
	endtask : t_ram

	task automatic t_periph_df();
		acc(1'b0, 1'b1, 24'h00f010, 32'h0, 1'b1);
		chk("size_err", 32'h1, 32'(periph_size_err_ff));
		acc(1'b0, 1'b0, 24'h00f010, 32'h0, 1'b1);
		chk("size_err", 32'h0, 32'(periph_size_err_ff));
		acc(1'b0, 1'b0, 24'h001fff, 32'h0, 1'b0);
		chk("df_geom", 32'({4'hf, 7'h0f}), 32'(df_geom_ff));
		$display("test periph_df done");
	endtask : t_periph_df

	task automatic t_pbus();
		pb(1'b0, 16'h5a00, {4'h5, 7'h2d});
		pb(1'b1, 16'h0b00, {4'h2, 7'h0b});
		$display("test pbus done");
	endtask : t_pbus

	task automatic t_vec();
		vec(16'h0200, 7'd0, 1'b0, 1'b0, 16'h0000, 1'b1);
		vec(16'h0000, 7'd0, 1'b1, 1'b0, 16'h0000, 1'b1);
		vec(16'h0000, 7'd0, 1'b1, 1'b1, 16'h0000, 1'b0);
		vec(16'h0200, 7'd81, 1'b0, 1'b0, 16'hfff5, 1'b0);
		$display("test vectors done");
	endtask : t_vec

	// mid-run reset: config words must be fetched again from scratch
	task automatic t_reset();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("rst_init_done", 32'h0, 32'(init_done_ff));
		chk("rst_cfg_word", 32'h0, 32'(flash_cfg_ff[8]));
		chk("rst_vec_target", 32'h0, 32'(vec_target_ff));
		@(posedge sys_clk);
		rst <= 1'b0;
		t_init();
		$display("test reset done");
	endtask : t_reset

	initial begin
		rst = 1'b1;
		dreq = '0;
		ext_data_mode_bit = 1'b0;
		boot_mode1 = 1'b0;
		ext_mem_mode = 1'b0;
		pbus_valid = 1'b0;
		pbus_boot = 1'b0;
		pbus_addr = 16'h0;
		vec_req = 1'b0;
		vector_base = 16'h0;
		vec_num = 7'h0;
		vec_lo = 16'h0;
		vec_hi = 16'h0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		t_init();
		t_decode();
		t_ram();
		t_periph_df();
		t_pbus();
		t_vec();
		t_reset();
		end_sim();
	end
endmodule : tb
`default_nettype wire
